// *** shared/stm_pkg.sv ***
// stm_pkg: offsets, field layouts and reset values for the sleep timer word
// assumes a 32-bit apb slave with word-aligned registers
package stm_pkg;
  localparam int STM_CNT_W = 10;
  localparam int STM_SLT_W = 19;
  localparam int STM_SEL_W = 2;
  // byte addresses within the block
  localparam logic [11:0] STM_OFF_WORD = 12'h000;
  localparam logic [11:0] STM_OFF_CTRL = 12'h004;
  localparam logic [11:0] STM_OFF_STAT = 12'h008;
  localparam logic [11:0] STM_OFF_SLEEP = 12'h00C;
  localparam logic [STM_CNT_W-1:0] STM_WORD_RST = 10'h000;
  localparam logic [STM_SEL_W-1:0] STM_SEL_RST = 2'h0;
  localparam logic [STM_SLT_W-1:0] STM_SLT_RST = 19'h00000;
  // readback selector codes
  localparam logic [STM_SEL_W-1:0] STM_SEL_SAVED = 2'h0;
  localparam logic [STM_SEL_W-1:0] STM_SEL_DUR = 2'h1;
  localparam logic [STM_SEL_W-1:0] STM_SEL_TLO = 2'h2;
  localparam logic [STM_SEL_W-1:0] STM_SEL_THI = 2'h3;
  localparam int STM_THI_LSB = 10;
  localparam int STM_THI_MSB = 18;
  // control register fields
  localparam int STM_CTRL_SEL_LSB = 0;
  localparam int STM_CTRL_SLEEP_BIT = 4;
  localparam int STM_CTRL_WAKE_BIT = 5;
  typedef enum logic [1:0] {STM_AWAKE, STM_SAVE, STM_ASLEEP, STM_RESTORE}
    stm_state_t;
endpackage : stm_pkg

// *** core/stm_readback.sv ***
// stm_readback: selector-driven read mux for the sleep timer word
// assumes inputs other than duration are registered in the caller's pclk domain
`timescale 1ns/1ps
module stm_readback (
  input wire logic [stm_pkg::STM_SEL_W-1:0] sel,
  input wire logic [stm_pkg::STM_CNT_W-1:0] saved,
  input wire logic [stm_pkg::STM_CNT_W-1:0] duration,
  input wire logic [stm_pkg::STM_SLT_W-1:0] sleep_time,
  input wire logic monitor,
  output logic [stm_pkg::STM_CNT_W-1:0] rdata
);
  import stm_pkg::*;
  always_comb begin
    case (sel)
      STM_SEL_DUR: rdata = duration; // [R4]
      STM_SEL_TLO: rdata = sleep_time[STM_CNT_W-1:0]; // [R5]
      STM_SEL_THI: rdata = {monitor,
        sleep_time[STM_THI_MSB:STM_THI_LSB]}; // [R6]
      default: rdata = saved; // [R2]
    endcase
  end
endmodule : stm_readback

// *** core/stm_sleep_timer.sv ***
// stm_sleep_timer: always-on sleep timer word behind an apb slave
// assumes apb master in pclk domain; radio core gives sleep/wake info
// Operation
// [R1] the fine slot counter is saved on sleep entry and restored on wake.
// [R2] selector zero reads back the saved counter.
// [R3] while awake the word is meaningless and writes never touch the radio.
// [R4] selector one reads sleep duration bits nine to zero.
// [R5] selector two reads sampled sleep time bits nine to zero.
// [R6] selector three reads monitor bit above sleep time bits 18 to 10.
// [R7] writes act the same whatever the selector holds.
// [R8] software leaves one idle cycle between a write and a read-back.
`timescale 1ns/1ps
module stm_sleep_timer #(
  parameter int FINE_W = stm_pkg::STM_CNT_W,
  parameter int SLT_W = stm_pkg::STM_SLT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [stm_pkg::STM_CNT_W-1:0] fine_slot_counter,
  input wire logic [stm_pkg::STM_CNT_W-1:0] sleep_duration,
  input wire logic [stm_pkg::STM_SLT_W-1:0] sleep_time_live,
  input wire logic sleep_ack,
  output logic fine_restore_valid,
  output logic [stm_pkg::STM_CNT_W-1:0] fine_restore_value,
  output logic core_asleep
);
  import stm_pkg::*;

  // read mux slices fixed field positions; other widths cannot be served
  if (FINE_W != STM_CNT_W || SLT_W != STM_SLT_W) begin : g_width_chk
    $error("stm_sleep_timer: unsupported counter or sleep time width");
  end

  stm_state_t state_r;
  logic [STM_CNT_W-1:0] timer_word_r;
  logic [STM_SEL_W-1:0] sel_r;
  logic [STM_SLT_W-1:0] slt_samp_r;
  logic monitor_r;
  logic sleep_req_r;
  logic wake_req_r;
  logic [STM_CNT_W-1:0] mux_rd;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic word_wr;
  logic ctrl_wr;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  assign wr_acc = psel && penable && pwrite && clk_en;
  assign rd_acc = psel && penable && !pwrite && clk_en;
  assign mapped = hit(paddr, STM_OFF_WORD) || hit(paddr, STM_OFF_CTRL) ||
    hit(paddr, STM_OFF_STAT) || hit(paddr, STM_OFF_SLEEP);
  // selector not decoded here: same write effect for every code
  assign word_wr = wr_acc && hit(paddr, STM_OFF_WORD) && pstrb[0]; // [R7]
  assign ctrl_wr = wr_acc && hit(paddr, STM_OFF_CTRL) && pstrb[0];
  assign pready = clk_en;
  assign pslverr = psel && penable && !mapped;
  assign core_asleep = (state_r == STM_ASLEEP);

  // sleep sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= STM_AWAKE;
    end else if (clk_en) begin
      case (state_r)
        STM_AWAKE: if (sleep_req_r && sleep_ack) state_r <= STM_SAVE;
        STM_SAVE: state_r <= STM_ASLEEP;
        STM_ASLEEP: if (wake_req_r) state_r <= STM_RESTORE;
        STM_RESTORE: state_r <= STM_AWAKE;
        default: state_r <= STM_AWAKE;
      endcase
    end
  end

  // request bits self-clear once the sequence consumes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= STM_SEL_RST;
      sleep_req_r <= 1'b0;
      wake_req_r <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        sel_r <= pwdata[STM_CTRL_SEL_LSB +: STM_SEL_W];
      end
      if (ctrl_wr && pwdata[STM_CTRL_SLEEP_BIT]) begin
        sleep_req_r <= 1'b1;
      end else if (state_r == STM_SAVE) begin
        sleep_req_r <= 1'b0;
      end
      if (ctrl_wr && pwdata[STM_CTRL_WAKE_BIT]) begin
        wake_req_r <= 1'b1;
      end else if (state_r == STM_RESTORE) begin
        wake_req_r <= 1'b0;
      end
    end
  end

  // hardware save beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_word_r <= STM_WORD_RST;
    end else if (clk_en) begin
      if (state_r == STM_SAVE) begin
        timer_word_r <= fine_slot_counter; // [R1]
      end else if (word_wr) begin
        timer_word_r <= pwdata[STM_CNT_W-1:0]; // [R7]
      end
    end
  end

  // sampled sleep time and monitor follow sleep entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slt_samp_r <= STM_SLT_RST;
      monitor_r <= 1'b0;
    end else if (clk_en) begin
      monitor_r <= (state_r == STM_ASLEEP);
      if (state_r == STM_ASLEEP || state_r == STM_RESTORE) begin
        slt_samp_r <= sleep_time_live;
      end
    end
  end

  // restore only at wake; awake writes never reach the radio
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fine_restore_valid <= 1'b0;
      fine_restore_value <= STM_WORD_RST;
    end else if (clk_en) begin
      fine_restore_valid <= (state_r == STM_RESTORE); // [R1] [R3]
      if (state_r == STM_RESTORE) begin
        fine_restore_value <= timer_word_r; // [R1]
      end
    end
  end

  stm_readback u_rb (
    .sel(sel_r),
    .saved(timer_word_r),
    .duration(sleep_duration),
    .sleep_time(slt_samp_r),
    .monitor(monitor_r),
    .rdata(mux_rd)
  );

  // registered read data; a read just after a write sees the new word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      if (hit(paddr, STM_OFF_WORD)) begin
        prdata <= {22'h000000, mux_rd}; // [R8]
      end else if (hit(paddr, STM_OFF_CTRL)) begin
        prdata <= {30'h00000000, sel_r};
      end else if (hit(paddr, STM_OFF_STAT)) begin
        prdata <= {29'h00000000, monitor_r, state_r};
      end else if (hit(paddr, STM_OFF_SLEEP)) begin
        prdata <= {13'h0000, slt_samp_r};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule : stm_sleep_timer

// *** tb/stm_sleep_timer_properties.sv ***
// stm_props: port checks for the sleep timer word
// assumes stm_sleep_timer ports, one pclk domain
`timescale 1ns/1ps
module stm_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [9:0] sleep_duration,
  input wire logic fine_restore_valid,
  input wire logic core_asleep
);
  import stm_pkg::*;
  logic [1:0] sel_r;
  wire acc = psel && penable;
  wire rdw = acc && !pwrite && paddr == STM_OFF_WORD;
  // shadow selector, only for the duration check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sel_r <= STM_SEL_RST;
    else if (acc && clk_en && pwrite && pstrb[0] && paddr == STM_OFF_CTRL)
      sel_r <= pwdata[1:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pulse; fine_restore_valid ##1 !fine_restore_valid; endsequence
  sequence s_restore; !core_asleep ##1 s_pulse; endsequence
  AST_PREADY: assert property (pready == clk_en) else $error("pready");
  AST_ERR: assert property (acc && paddr > STM_OFF_SLEEP |-> pslverr)
    else $error("no slverr");
  AST_NOERR: assert property (!acc |-> !pslverr) else $error("slverr");
  AST_UPPER: assert property (rdw |-> prdata[31:10] == 22'h0)
    else $error("upper bits");
  AST_DUR: assert property (rdw && clk_en && $past(clk_en)
    && sel_r == STM_SEL_DUR |-> prdata[9:0] == $past(sleep_duration))
    else $error("duration");
  AST_PULSE: assert property ($rose(fine_restore_valid) |-> s_pulse)
    else $error("pulse");
  AST_RESTORE: assert property ($fell(core_asleep) |-> s_restore)
    else $error("restore");
  AST_AWAKE: assert property (core_asleep |-> !fine_restore_valid)
    else $error("early restore");
endmodule : stm_props
bind stm_sleep_timer stm_props stm_props_i (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .sleep_duration, .fine_restore_valid, .core_asleep);

// *** tb/test_sleep_timer_readback_mux.sv ***
// test_sleep_timer_readback_mux: apb bench with inline expected values
// assumes stm_sleep_timer with the bound stm_props checker
`timescale 1ns/1ps
module test_sleep_timer_readback_mux;
  import stm_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0;
  logic penable = 1'h0, pwrite = 1'h0, sleep_ack = 1'h0, pready, pslverr;
  logic fine_restore_valid, core_asleep, perr;
  logic [3:0] pstrb = 4'hF;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, r32;
  logic [9:0] fine_slot_counter = 10'h0, sleep_duration = 10'h0;
  logic [9:0] fine_restore_value, mw;
  logic [18:0] sleep_time_live = 19'h0;
  int n_mismatch = 0, num_checks = 0;
  int unsigned seed = 32'h000136ED;
  stm_sleep_timer stm_sleep_timer_i (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .fine_slot_counter, .sleep_duration, .sleep_time_live, .sleep_ack,
    .fine_restore_valid, .fine_restore_value, .core_asleep);
  initial forever #10 pclk = ~pclk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      n_mismatch++;
    end
  endtask : ck
  // bounded wait; a flag that never comes ends the run
  task automatic wt(ref logic f);
    num_checks++;
    for (int k = 0; k < 8; k++) begin
      if (f === 1'h1)
        return;
      @(posedge pclk);
    end
    n_mismatch++;
    test_done();
  endtask : wt
  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // access phase held until pready is seen high at an edge
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      if (pready === 1'h1)
        break;
    end
    if (pready !== 1'h1) begin
      n_mismatch++;
      test_done();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : ap
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    ap(1'h0, STM_OFF_WORD, 32'h0);
    ck(rd, 32'h0);
    r32 = xs();
    mw = r32[9:0];
    ap(1'h1, STM_OFF_WORD, {22'h0, mw});
    pstrb <= 4'h0;
    ap(1'h1, STM_OFF_WORD, ~r32);
    pstrb <= 4'hF;
    ap(1'h0, STM_OFF_WORD, 32'h0);
    ck(rd, {22'h0, mw});
    r32 = xs();
    fine_slot_counter <= r32[9:0];
    sleep_duration <= r32[19:10];
    sleep_time_live <= r32[31:13];
    sleep_ack <= 1'h1;
    ap(1'h1, STM_OFF_CTRL, 32'h10);
    wt(core_asleep);
    fine_slot_counter <= ~r32[9:0];
    ap(1'h0, STM_OFF_WORD, 32'h0);
    ck(rd, {22'h0, r32[9:0]});
    ap(1'h0, STM_OFF_STAT, 32'h0);
    ck(rd, 32'h6);
    ap(1'h0, STM_OFF_SLEEP, 32'h0);
    ck(rd, {13'h0, r32[31:13]});
    for (int q = 1; q < 4; q++) begin
      ap(1'h1, STM_OFF_CTRL, 32'(q));
      ap(1'h0, STM_OFF_WORD, 32'h0);
      ck(rd, q == 1 ? r32[19:10] : q == 2 ? r32[22:13] :
        {1'h1, r32[31:23]});
    end
    r32 = xs();
    mw = r32[9:0];
    ap(1'h1, STM_OFF_WORD, {22'h0, mw});
    ap(1'h1, STM_OFF_CTRL, 32'h20);
    wt(fine_restore_valid);
    ck(fine_restore_value, mw);
    ap(1'h1, STM_OFF_WORD, ~r32);
    repeat (3) begin
      @(posedge pclk);
      ck(fine_restore_valid, 32'h0);
    end
    ap(1'h0, 12'h010, 32'h0);
    ck({rd[30:0], perr}, 32'h1);
    clk_en <= 1'h0;
    @(posedge pclk);
    ck(pready, 32'h0);
    clk_en <= 1'h1;
    test_done();
  end
endmodule : test_sleep_timer_readback_mux
